/* src/qec_top.sv */
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "qec_params.svh"
module qec_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Encoder pins
    input wire qec_pkg::qec_pins_t pins,
    // AXI4-Lite write
    input wire logic [4:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [4:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Status
    output logic [31:0] position,
    output logic index_match
);
    import qec_pkg::*;

    // ==========================================================
    // Registers
    logic [15:0] encoder_control;
    logic [3:0] conf;
    logic [31:0] index_capture_register;
    logic [31:0] greater_equal_compare_register;
    logic [31:0] pos;
    logic aw_held, w_held;
    logic [4:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic pos_wr;

    // ==========================================================
    // Pin synchronisers, three stages
    qec_pins_t s1, s2, s3, st;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            st <= '0;
        end else begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
            st <= (s2 == s3) ? s3 : st;
        end
    end

    // ==========================================================
    // Count clock divider
    logic [7:0] div_cnt;
    logic tick;
    logic [2:0] div_sel;
    assign div_sel = encoder_control[`QEC_B_DIV +: 3];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 8'h00;
            tick <= 1'b0;
        end else begin
            tick <= (div_cnt == 8'((1 << div_sel) - 1));
            div_cnt <= (div_cnt == 8'((1 << div_sel) - 1)) ? 8'h00 : 8'(div_cnt + 8'h01);
        end
    end

    // ==========================================================
    // Phase conditioning and index match
    logic pa, pb, run, timer_mode, match;
    logic [1:0] counter_mode_field;
    qec_position_init_mode_t pim;
    assign pa = (conf[`QEC_B_SWAP] ? st.b : st.a) ^ conf[`QEC_B_APOL];
    assign pb = (conf[`QEC_B_SWAP] ? st.a : st.b) ^ conf[`QEC_B_BPOL];
    assign counter_mode_field = encoder_control[`QEC_B_CCM +: 2];
    assign pim = qec_position_init_mode_t'(encoder_control[`QEC_B_PIM +: 3]);
    assign timer_mode = counter_mode_field[1];
    assign match = (pa == encoder_control[`QEC_B_IMVA])
        && (pb == encoder_control[`QEC_B_IMVB]);
    assign run = encoder_control[`QEC_B_EN]
        && !(encoder_control[`QEC_B_SIDL] && conf[`QEC_B_IDLE]);

    // ==========================================================
    // Index and home event detection
    logic idx_d, home_d, idx_ev, home_ev;
    logic [1:0] home_idx;
    logic armed;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx_d <= 1'b0;
            home_d <= 1'b0;
        end else begin
            idx_d <= st.idx;
            home_d <= st.home;
        end
    end
    assign idx_ev = st.idx && !idx_d && match;
    assign home_ev = st.home && !home_d;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed <= 1'b0;
            home_idx <= 2'b00;
        end else if (!run) begin
            armed <= armed;
        end else if (home_ev) begin
            armed <= 1'b1;
            home_idx <= 2'b00;
        end else if (idx_ev && armed) begin
            home_idx <= 2'(home_idx + 2'b01);
            armed <= !((pim == QEC_PI_HOME1) || (home_idx == 2'b01));
        end
    end

    // ==========================================================
    // Position counter
    logic prev_a, prev_b, step, up;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end else if (tick) begin
            prev_a <= pa;
            prev_b <= pb;
        end
    end
    assign step = tick && ((pa ^ prev_a) || (pb ^ prev_b));
    assign up = ((pa ^ prev_b) ^ encoder_control[`QEC_B_CPOL]);
    logic load_ic, clr_idx, clr_gec;
    always_comb begin
        load_ic = 1'b0;
        clr_gec = 1'b0;
        clr_idx = 1'b0;
        if (!timer_mode) begin
            case (pim)
                QEC_PI_EVERY: clr_idx = idx_ev;
                QEC_PI_NEXT: load_ic = idx_ev;
                QEC_PI_HOME1: load_ic = idx_ev && armed && home_idx == 2'b00;
                QEC_PI_HOME2: load_ic = idx_ev && armed && home_idx == 2'b01;
                QEC_PI_GEC: clr_gec = (pos == greater_equal_compare_register);
                default: load_ic = 1'b0;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos <= 32'h0000_0000;
        end else if (pos_wr) begin
            pos <= w_data;
        end else if (!run) begin
            pos <= pos;
        end else if (counter_mode_field == 2'b00 && match) begin
            pos <= 32'h0000_0000;
        end else if (load_ic) begin
            pos <= index_capture_register;
        end else if (clr_gec || clr_idx) begin
            pos <= 32'h0000_0000;
        end else if (timer_mode) begin
            pos <= (tick && (!encoder_control[`QEC_B_GATE] || st.a)) ? pos + 32'h0000_0001 : pos;
        end else if (step) begin
            pos <= up ? pos + 32'h0000_0001 : pos - 32'h0000_0001;
        end
    end

    // ==========================================================
    // AXI4-Lite write path
    logic do_wr;
    assign do_wr = aw_held && w_held && !s_bvalid;
    assign pos_wr = do_wr && aw_addr == 5'(`QEC_POS_ADDR);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            aw_addr <= 5'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
        end else begin
            if (s_awvalid && s_awready) begin
                s_awready <= 1'b0;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                s_wready <= 1'b0;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (do_wr) begin
                s_awready <= 1'b1;
                s_wready <= 1'b1;
                s_bvalid <= 1'b1;
                s_bresp <= (aw_addr[1:0] == 2'b00 && aw_addr <= `QEC_GEC_ADDR) ? 2'b00 : 2'b10;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end
    assign aw_held = !s_awready;
    assign w_held = !s_wready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            encoder_control <= `QEC_CTRL_RESET;
            conf <= 4'h0;
            index_capture_register <= 32'h0000_0000;
            greater_equal_compare_register <= 32'h0000_0000;
        end else if (do_wr) begin
            case (aw_addr)
                `QEC_CTRL_ADDR: begin
                    if (w_strb[0])
                        encoder_control[7:0] <= w_data[7:0] & 8'(`QEC_CTRL_MASK);
                    if (w_strb[1])
                        encoder_control[15:8] <= w_data[15:8] & 8'(`QEC_CTRL_MASK >> 8);
                end
                `QEC_CONF_ADDR: if (w_strb[0]) conf <= w_data[3:0];
                `QEC_ICAP_ADDR: index_capture_register <= w_data;
                `QEC_GEC_ADDR: greater_equal_compare_register <= w_data;
                default: conf <= conf;
            endcase
        end
    end

    // ==========================================================
    // AXI4-Lite read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= 2'b00;
            s_arready <= 1'b1;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_arready <= 1'b0;
            s_rresp <= 2'b00;
            case (s_araddr)
                `QEC_CTRL_ADDR: s_rdata <= {16'h0000, encoder_control & `QEC_CTRL_MASK};
                `QEC_CONF_ADDR: s_rdata <= {28'h000_0000, conf};
                `QEC_POS_ADDR: s_rdata <= pos;
                `QEC_ICAP_ADDR: s_rdata <= index_capture_register;
                `QEC_GEC_ADDR: s_rdata <= greater_equal_compare_register;
                default: begin
                    s_rdata <= 32'h0000_0000;
                    s_rresp <= 2'b10;
                end
            endcase
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
        end
    end

    // ==========================================================
    // Status outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            position <= 32'h0000_0000;
            index_match <= 1'b0;
        end else begin
            position <= pos;
            index_match <= match;
        end
    end

    // ==========================================================
    // Checks
    a_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        (!run && !pos_wr) |=> $stable(pos)) else $error("count moved while stopped");
    a_idle_halts: assert property (@(posedge aclk) disable iff (!aresetn)
        (encoder_control[`QEC_B_SIDL] && conf[`QEC_B_IDLE] && !pos_wr) |=> $stable(pos))
        else $error("count moved while idle");
    a_match_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && !pos_wr && counter_mode_field == 2'b00 && match) |=> pos == 0) else $error("match no clear");
    a_next_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && !pos_wr && counter_mode_field == 2'b01 && pim == QEC_PI_NEXT && idx_ev)
        |=> pos == $past(index_capture_register)) else $error("index load missed");
    a_gec_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && !pos_wr && counter_mode_field == 2'b01 && pim == QEC_PI_GEC
        && pos == greater_equal_compare_register) |=> pos == 0) else $error("gec clear");
    a_timer_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && !pos_wr && timer_mode) |=> pos - $past(pos) <= 1) else $error("timer took init");
    a_ctrl_unused: assert property (@(posedge aclk) disable iff (!aresetn)
        encoder_control[14] == 1'b0 && encoder_control[7] == 1'b0) else $error("bit set");
    a_match_level: assert property (@(posedge aclk) disable iff (!aresetn)
        (conf[2:0] == 3'b000 && st.a != encoder_control[`QEC_B_IMVA]
        || conf[2:0] == 3'b111 && st.b == encoder_control[`QEC_B_IMVA]) |=> !index_match)
        else $error("match level wrong");
endmodule : qec_top
`default_nettype wire

/* src/qec_params.svh */
`ifndef QEC_PARAMS_SVH
`define QEC_PARAMS_SVH
`define QEC_CTRL_ADDR 5'h00
`define QEC_CONF_ADDR 5'h04
`define QEC_POS_ADDR 5'h08
`define QEC_ICAP_ADDR 5'h0C
`define QEC_GEC_ADDR 5'h10
`define QEC_CTRL_MASK 16'hBF7F
`define QEC_CTRL_RESET 16'h0000
`define QEC_B_EN 15
`define QEC_B_SIDL 13
`define QEC_B_PIM 10
`define QEC_B_IMVB 9
`define QEC_B_IMVA 8
`define QEC_B_DIV 4
`define QEC_B_CPOL 3
`define QEC_B_GATE 2
`define QEC_B_CCM 0
`define QEC_B_SWAP 0
`define QEC_B_APOL 1
`define QEC_B_BPOL 2
`define QEC_B_IDLE 3
`endif

/* src/qec_pkg.sv */
package qec_pkg;
    typedef enum logic [2:0] {
        QEC_PI_FREE, QEC_PI_EVERY, QEC_PI_NEXT, QEC_PI_HOME1,
        QEC_PI_HOME2, QEC_PI_GEC, QEC_PI_MOD, QEC_PI_RSVD
    } qec_position_init_mode_t;
    typedef struct packed {
        logic a;
        logic b;
        logic idx;
        logic home;
    } qec_pins_t;
endpackage : qec_pkg

/* testbench/qec_enc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module qec_enc_model (
    // Clock
    input wire logic aclk,
    // Encoder outputs
    output var qec_pkg::qec_pins_t pins
);
    import qec_pkg::*;
    // =====================================
    // Encoder behaviour.
    // Every level is held long enough for the synchroniser and the count clock.
    localparam int HOLD = 8;
    initial pins = '0;
    task automatic phases(input logic a, input logic b);
        @(posedge aclk);
        pins.a <= a;
        pins.b <= b;
        repeat (HOLD) @(posedge aclk);
    endtask : phases
    task automatic pulse(input logic home);
        @(posedge aclk);
        if (home) pins.home <= 1'b1;
        else pins.idx <= 1'b1;
        repeat (HOLD) @(posedge aclk);
        pins.home <= 1'b0;
        pins.idx <= 1'b0;
        repeat (HOLD) @(posedge aclk);
    endtask : pulse
endmodule : qec_enc_model
`default_nettype wire

/* testbench/tb_quadrature_encoder_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qec_params.svh"
module tb_quadrature_encoder_control;
    import qec_pkg::*;
    localparam logic [4:0] a_ctl = 5'(`QEC_CTRL_ADDR);
    localparam logic [4:0] a_cnf = 5'(`QEC_CONF_ADDR);
    localparam logic [4:0] a_pos = 5'(`QEC_POS_ADDR);
    localparam logic [4:0] a_icp = 5'(`QEC_ICAP_ADDR);
    localparam logic [4:0] a_gec = `QEC_GEC_ADDR;
    logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, index_match;
    logic [4:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, position;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    qec_pins_t pins;
    int err_total, checks_done;
    qec_top dut (.aclk, .aresetn, .pins, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .position,
        .index_match);
    qec_enc_model enc (.aclk(aclk), .pins(pins));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // =====================================
    // Shared tasks.
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w;
        n = 0;
        aw = 1'b0;
        w = 1'b0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (s_bready && s_bvalid) begin
                s_bready <= 1'b0;
                chk(s_bresp === er, "write response");
                break;
            end
            if (s_awvalid && s_awready) begin
                s_awvalid <= 1'b0;
                aw = 1'b1;
            end
            if (s_wvalid && s_wready) begin
                s_wvalid <= 1'b0;
                w = 1'b1;
            end
            if (aw && w) s_bready <= 1'b1;
            if (n > 50) begin
                chk(1'b0, "write hang");
                break;
            end
        end
    endtask : wr
    task automatic rchk(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (s_rready && s_rvalid) begin
                s_rready <= 1'b0;
                chk(s_rdata === e && s_rresp === er, "read data or response");
                break;
            end
            if (s_arvalid && s_arready) begin
                s_arvalid <= 1'b0;
                s_rready <= 1'b1;
            end
            if (n > 50) begin
                chk(1'b0, "read hang");
                break;
            end
        end
    endtask : rchk
    function automatic logic [31:0] ctl(input logic en, input logic sidl,
        input logic [2:0] pim, input logic [1:0] index_match_value, input logic [1:0] counter_mode_field);
        return {16'h0000, en, 1'b0, sidl, pim, index_match_value, 6'h00, counter_mode_field};
    endfunction : ctl
    // =====================================
    // Scenarios.
    task automatic t_regs;
        rchk(a_ctl, 32'h0000_0000, 2'b00);
        wr(a_ctl, 32'h0000_FFFF, 2'b00);
        rchk(a_ctl, 32'h0000_BF7F, 2'b00);
        wr(5'h14, 32'h0000_FFFF, 2'b10);
        rchk(5'h14, 32'h0000_0000, 2'b10);
        $display("test regs done");
    endtask : t_regs
    task automatic t_match;
        logic [1:0] index_match_value;
        logic sw, pa, pb;
        for (int c = 0; c < 8; c++) begin
            index_match_value = 2'(c);
            sw = c[2];
            pa = (sw ? index_match_value[1] : index_match_value[0]) ^ sw;
            pb = (sw ? index_match_value[0] : index_match_value[1]) ^ sw;
            wr(a_cnf, {29'h0, sw, sw, sw}, 2'b00);
            wr(a_ctl, ctl(1'b1, 1'b0, 3'h0, index_match_value, 2'h0), 2'b00);
            enc.phases(~pa, pb);
            wr(a_pos, 32'h0000_1234, 2'b00);
            chk(index_match === 1'b0, "match while phase A differs");
            rchk(a_pos, 32'h0000_1234, 2'b00);
            enc.phases(pa, ~pb);
            chk(index_match === 1'b0, "match while phase B differs");
            enc.phases(pa, pb);
            cyc(4);
            chk(index_match === 1'b1, "no match");
            chk(position === 32'h0000_0000, "match did not clear");
        end
        $display("test match done");
    endtask : t_match
    task automatic t_init;
        logic [31:0] e;
        wr(a_cnf, 32'h0000_0000, 2'b00);
        wr(a_gec, 32'h0000_FFFF, 2'b00);
        wr(a_icp, 32'h0000_5A5A, 2'b00);
        enc.phases(1'b0, 1'b0);
        for (int p = 0; p < 8; p++) begin
            wr(a_ctl, ctl(1'b1, 1'b0, 3'(p), 2'h0, 2'h1), 2'b00);
            wr(a_pos, 32'h0000_0011, 2'b00);
            enc.pulse(1'b0);
            e = (p == 1) ? 32'h0 : (p == 2) ? 32'h0000_5A5A : 32'h0000_0011;
            chk(position === e, "index without home");
        end
        for (int k = 1; k < 3; k++) begin
            wr(a_ctl, ctl(1'b1, 1'b0, 3'(k + 2), 2'h0, 2'h1), 2'b00);
            wr(a_pos, 32'h0000_0011, 2'b00);
            enc.pulse(1'b1);
            for (int j = 0; j < k; j++) begin
                enc.pulse(1'b0);
                e = (j == k - 1) ? 32'h0000_5A5A : 32'h0000_0011;
                chk(position === e, "index after home");
            end
        end
        wr(a_ctl, ctl(1'b1, 1'b0, 3'h2, 2'h0, 2'h2) | (32'h0000_0001 << `QEC_B_GATE), 2'b00);
        wr(a_pos, 32'h0000_0011, 2'b00);
        enc.pulse(1'b0);
        chk(position === 32'h0000_0011, "timer mode took init");
        wr(a_ctl, ctl(1'b0, 1'b0, 3'h2, 2'h0, 2'h1), 2'b00);
        wr(a_pos, 32'h0000_0011, 2'b00);
        rchk(a_pos, 32'h0000_0011, 2'b00);
        enc.pulse(1'b0);
        chk(position === 32'h0000_0011, "disabled counter loaded");
        $display("test init done");
    endtask : t_init
    task automatic t_gec;
        wr(a_ctl, ctl(1'b1, 1'b0, 3'h0, 2'h0, 2'h1), 2'b00);
        wr(a_gec, 32'h0000_0007, 2'b00);
        wr(a_pos, 32'h0000_0007, 2'b00);
        cyc(4);
        chk(position === 32'h0000_0007, "free mode changed count");
        wr(a_ctl, ctl(1'b1, 1'b0, 3'h5, 2'h0, 2'h1), 2'b00);
        cyc(4);
        chk(position === 32'h0000_0000, "compare reset missing");
        wr(a_ctl, ctl(1'b1, 1'b0, 3'h7, 2'h0, 2'h1), 2'b00);
        wr(a_pos, 32'h0000_0007, 2'b00);
        cyc(4);
        chk(position === 32'h0000_0007, "reserved mode acted");
        $display("test compare done");
    endtask : t_gec
    task automatic t_run(input logic [31:0] c, input logic [31:0] cf, input logic mv);
        logic [31:0] p0;
        wr(a_cnf, cf, 2'b00);
        wr(a_ctl, c, 2'b00);
        cyc(4);
        p0 = position;
        cyc(16);
        chk((position !== p0) === mv, "run or stop");
        $display("test run done");
    endtask : t_run
    initial begin
        #500_000;
        err_total++;
        stop_test();
    end
    initial begin
        aresetn = 1'b0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        s_awaddr = '0;
        s_araddr = '0;
        s_wdata = '0;
        s_wstrb = 4'hF;
        err_total = 0;
        checks_done = 0;
        cyc(3);
        aresetn <= 1'b1;
        cyc(1);
        t_regs();
        t_match();
        t_init();
        t_gec();
        t_run(ctl(1'b1, 1'b0, 3'h0, 2'h0, 2'h2), 32'h0, 1'b1);
        t_run(ctl(1'b0, 1'b0, 3'h0, 2'h0, 2'h2), 32'h0, 1'b0);
        t_run(ctl(1'b1, 1'b1, 3'h0, 2'h0, 2'h3), 32'h8, 1'b0);
        t_run(ctl(1'b1, 1'b0, 3'h0, 2'h0, 2'h3), 32'h8, 1'b1);
        stop_test();
    end
endmodule : tb_quadrature_encoder_control
`default_nettype wire
